// ---- hdl/counter_channel_pkg.sv ----
// constants, fields and carriers of the counter-array channel 0 block
// assumes a 10 MHz single clock and a classic wishbone register bus

package counter_channel_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned WB_DW   = 32;
  localparam int unsigned REG_W   = 8;
  localparam int unsigned CNT_W   = 16;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMP_LOW   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP_HIGH  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MASK      = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PWM_WIDTH = 8'h14;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_MODE      = 8'h00;
  localparam logic [CNT_W-1:0] RST_COMPARE   = 16'h0000;
  localparam logic [1:0]       RST_STATUS    = 2'h0;
  localparam logic [1:0]       RST_MASK      = 2'h0;
  localparam logic [1:0]       RST_PWM_WIDTH = 2'h0;

  // ---------------------------------------------------------------
  // pwm width: narrow modes are base plus the width field
  // ---------------------------------------------------------------
  localparam logic [4:0]       PWM_BASE_BITS = 5'h08;
  localparam logic [CNT_W-1:0] ALL_ONES      = 16'hFFFF;

  // ---------------------------------------------------------------
  // channel_mode_control layout, bit 7 down to bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wide_resolution_select;
    logic comparator_enable;
    logic rise_capture_enable;
    logic fall_capture_enable;
    logic match_flag_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic event_irq_enable;
  } mode_s;

  // ---------------------------------------------------------------
  // status and mask layout, bit 1 down to bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic capture_event;
    logic channel_event_flag;
  } status_s;

  // ---------------------------------------------------------------
  // output behaviour decoded from the mode bits
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OUT_HOLD,
    OUT_TOGGLE,
    OUT_PWM,
    OUT_FREQ
  } out_mode_e;

endpackage : counter_channel_pkg

// ---- hdl/channel_edge_sync.sv ----
// three-flop synchroniser with edge pulses for the channel input pin
// assumes the pin is asynchronous to clk_i

module channel_edge_sync
  import counter_channel_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin
  input  wire logic pin_i,
  // edge pulses
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise_o = (st.s2 == st.s3) && st.s3 && !st.level;
  assign fall_o = (st.s2 == st.s3) && !st.s3 && st.level;

endmodule : channel_edge_sync

// ---- hdl/channel_output.sv ----
// comparator and waveform generator of channel 0
// assumes counter_i and tick_i come from the shared counter on clk_i

module channel_output
  import counter_channel_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // configuration
  input  wire mode_s            mode_i,
  input  wire logic [1:0]       pwm_width_i,
  input  wire logic [CNT_W-1:0] compare_i,
  // shared counter
  input  wire logic [CNT_W-1:0] counter_i,
  input  wire logic             tick_i,
  // results
  output logic                  match_o,
  output logic                  pin_o
);

  typedef struct packed {
    logic pin;
  } out_s;

  out_s       st;
  out_s       next_st;
  out_mode_e  omode;
  logic [CNT_W-1:0] pmask;
  logic       eq_full;
  logic       eq_low;
  logic       eq_pwm;

  assign pmask = mode_i.wide_resolution_select ? ALL_ONES
               : ~(ALL_ONES << (PWM_BASE_BITS + {3'h0, pwm_width_i}));
  assign eq_full = counter_i == compare_i;
  assign eq_low  = counter_i[7:0] == compare_i[7:0];
  assign eq_pwm  = (counter_i & pmask) == (compare_i & pmask);

  always_comb begin
    if (mode_i.pwm_enable && mode_i.toggle_enable) begin
      omode = OUT_FREQ;
    end else if (mode_i.pwm_enable) begin
      omode = OUT_PWM;
    end else if (mode_i.toggle_enable) begin
      omode = OUT_TOGGLE;
    end else begin
      omode = OUT_HOLD;
    end
  end

  // ---------------------------------------------------------------
  // match and pin
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    match_o = 1'b0;
    unique case (omode)
      OUT_HOLD: begin
        match_o = mode_i.comparator_enable && tick_i && eq_full;
      end
      OUT_TOGGLE: begin
        match_o = mode_i.comparator_enable && tick_i && eq_full;
        if (match_o) begin
          next_st.pin = !st.pin;
        end
      end
      OUT_PWM: begin
        match_o = mode_i.comparator_enable && tick_i && eq_pwm;
        next_st.pin = mode_i.comparator_enable
                    && ((counter_i & pmask) < (compare_i & pmask));
      end
      OUT_FREQ: begin
        match_o = mode_i.comparator_enable && tick_i && eq_low;
        if (match_o) begin
          next_st.pin = !st.pin;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_o = st.pin;

endmodule : channel_output

// ---- hdl/counter_channel.sv ----
// channel 0 mode control of the counter array with a wishbone slave
// assumes the shared counter, its tick and the channel pin sit outside
//
// Added by the designer: the register offsets and the Wishbone slave port.

module counter_channel
  import counter_channel_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [WB_DW-1:0]  wb_dat_i,
  output logic [WB_DW-1:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // shared counter
  input  wire logic [CNT_W-1:0]  counter_i,
  input  wire logic              counter_tick_i,
  // channel pins
  input  wire logic              channel_input_pin_i,
  output logic                   channel_output_pin_o,
  // interrupt
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    mode_s            mode;
    logic [CNT_W-1:0] compare;
    status_s          status;
    status_s          mask;
    logic [1:0]       pwm_width;
    logic             ack;
    logic [REG_W-1:0] rdata;
  } top_s;

  top_s st;
  top_s next_st;

  // ---------------------------------------------------------------
  // internal signals
  // ---------------------------------------------------------------
  logic             req;
  logic             wr;
  logic             rd;
  logic             lane0;
  logic [REG_W-1:0] wbyte;
  logic             hit_mode;
  logic             hit_low;
  logic             hit_high;
  logic             hit_status;
  logic             hit_mask;
  logic             hit_width;
  logic             edge_rise;
  logic             edge_fall;
  logic             capture;
  logic             match;
  logic [REG_W-1:0] read_mux;
  status_s          set_bits;
  status_s          clr_bits;
  status_s          gate;

  // ---------------------------------------------------------------
  // input edge detection
  // ---------------------------------------------------------------
  channel_edge_sync u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (channel_input_pin_i),
    .rise_o (edge_rise),
    .fall_o (edge_fall)
  );

  // ---------------------------------------------------------------
  // comparator and output wave
  // ---------------------------------------------------------------
  channel_output u_out (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .mode_i      (st.mode),
    .pwm_width_i (st.pwm_width),
    .compare_i   (st.compare),
    .counter_i   (counter_i),
    .tick_i      (counter_tick_i),
    .match_o     (match),
    .pin_o       (channel_output_pin_o)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign req   = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr    = req && wb_we_i;
  assign rd    = req && !wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign wbyte = wb_dat_i[REG_W-1:0];

  assign hit_mode   = wb_adr_i == OFS_MODE;
  assign hit_low    = wb_adr_i == OFS_CMP_LOW;
  assign hit_high   = wb_adr_i == OFS_CMP_HIGH;
  assign hit_status = wb_adr_i == OFS_STATUS;
  assign hit_mask   = wb_adr_i == OFS_MASK;
  assign hit_width  = wb_adr_i == OFS_PWM_WIDTH;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    read_mux = '0;
    if (hit_mode) begin
      read_mux = st.mode;
    end else if (hit_low) begin
      read_mux = st.compare[7:0];
    end else if (hit_high) begin
      read_mux = st.compare[15:8];
    end else if (hit_status) begin
      read_mux = {6'h00, st.status};
    end else if (hit_mask) begin
      read_mux = {6'h00, st.mask};
    end else if (hit_width) begin
      read_mux = {6'h00, st.pwm_width};
    end
  end

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  assign capture = (st.mode.rise_capture_enable && edge_rise)
                || (st.mode.fall_capture_enable && edge_fall);

  always_comb begin
    set_bits                    = '0;
    set_bits.capture_event      = capture;
    set_bits.channel_event_flag = capture
                               || (st.mode.match_flag_enable && match);
  end

  always_comb begin
    clr_bits = '0;
    if (wr && lane0 && hit_status) begin
      clr_bits = wbyte[1:0];
    end
  end

  // ---------------------------------------------------------------
  // interrupt gating
  // ---------------------------------------------------------------
  always_comb begin
    gate                    = st.mask;
    gate.channel_event_flag = st.mask.channel_event_flag
                           && st.mode.event_irq_enable;
  end

  assign irq_o = |(st.status & gate);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.ack   = req;
    next_st.rdata = rd ? read_mux : st.rdata;

    // software writes, lane 0 only
    if (wr && lane0) begin
      if (hit_mode) begin
        next_st.mode = wbyte;
      end
      if (hit_width) begin
        next_st.pwm_width = wbyte[1:0];
      end
      if (hit_mask) begin
        next_st.mask = wbyte[1:0];
      end
      if (hit_low) begin
        next_st.compare[7:0]           = wbyte;
        next_st.mode.comparator_enable = 1'b0;
      end
      if (hit_high) begin
        next_st.compare[15:8]          = wbyte;
        next_st.mode.comparator_enable = 1'b1;
      end
    end

    // capture has priority over a same-cycle compare write
    if (capture) begin
      next_st.compare = counter_i;
    end

    // set wins over write-one-to-clear
    next_st.status = (st.status & ~clr_bits) | set_bits;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.mode      <= RST_MODE;
      st.compare   <= RST_COMPARE;
      st.status    <= RST_STATUS;
      st.mask      <= RST_MASK;
      st.pwm_width <= RST_PWM_WIDTH;
      st.ack       <= 1'b0;
      st.rdata     <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // bus outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = st.ack;
  assign wb_dat_o = {24'h000000, st.rdata};

endmodule : counter_channel

// ---- dv/counter_channel_properties.sv ----
// checker of the counter-array channel 0 block
// assumes binding to counter_channel, sees only its ports

module counter_channel_properties
  import counter_channel_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // wishbone
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [WB_DW-1:0]  wb_dat_i,
  input wire logic [WB_DW-1:0]  wb_dat_o,
  input wire logic              wb_ack_o,
  // counter, pins, interrupt
  input wire logic [CNT_W-1:0]  counter_i,
  input wire logic              counter_tick_i,
  input wire logic              channel_input_pin_i,
  input wire logic              channel_output_pin_o,
  input wire logic              irq_o
);
  // ---------------------------------------------------------------
  // shadow of software state
  // ---------------------------------------------------------------
  logic [7:0]       mode;
  logic [1:0]       msk;
  logic [1:0]       wid;
  logic [CNT_W-1:0] cmp;
  logic [1:0]       known;
  logic [CNT_W-1:0] pm;
  logic             take;
  logic             wr;
  logic             lt;
  logic             tg;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr   = take && wb_we_i && wb_sel_i[0];
  assign pm   = mode[7] ? ALL_ONES : (16'h0100 << wid) - 16'h0001;
  assign lt   = (counter_i & pm) < (cmp & pm);
  assign tg   = counter_tick_i && mode[6] && mode[2] && (&known);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode  <= 8'h00;
      msk   <= 2'h0;
      wid   <= 2'h0;
      cmp   <= 16'h0000;
      known <= 2'h0;
    end else begin
      if (wr && wb_adr_i == OFS_MODE) mode <= wb_dat_i[7:0];
      if (wr && wb_adr_i == OFS_MASK) msk <= wb_dat_i[1:0];
      if (wr && wb_adr_i == OFS_PWM_WIDTH) wid <= wb_dat_i[1:0];
      if (wr && wb_adr_i == OFS_CMP_LOW) begin
        mode[6]  <= 1'b0;
        cmp[7:0] <= wb_dat_i[7:0];
        known[0] <= 1'b1;
      end
      if (wr && wb_adr_i == OFS_CMP_HIGH) begin
        mode[6]   <= 1'b1;
        cmp[15:8] <= wb_dat_i[7:0];
        known[1]  <= 1'b1;
      end
      if (mode[5] || mode[4]) known <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (take |=> wb_ack_o) else $error("no ack");
  a_mode_readback: assert property (take && !wb_we_i && wb_adr_i == OFS_MODE
    |=> wb_dat_o == {24'h000000, mode}) else $error("mode readback wrong");
  a_irq_blocked: assert property (!(mode[0] && msk[0]) && !msk[1] |-> !irq_o)
    else $error("irq while blocked");
  a_pin_holds: assert property (!mode[1] && !(mode[2] && mode[6])
    |=> $stable(channel_output_pin_o)) else $error("pin moved");
  a_toggle_flip: assert property (tg && !mode[1] && counter_i == cmp
    |=> channel_output_pin_o != $past(channel_output_pin_o)) else $error("no toggle");
  a_freq_flip: assert property (tg && mode[1] && counter_i[7:0] == cmp[7:0]
    |=> channel_output_pin_o != $past(channel_output_pin_o)) else $error("no freq flip");
  a_match_irq: assert property (counter_tick_i && mode[6] && mode[3] && mode[0] && msk[0]
    && !mode[1] && (&known) && counter_i == cmp && !wb_stb_i |=> irq_o) else $error("no flag");
  a_pwm_level: assert property (counter_tick_i && mode[6] && mode[1] && !mode[2] && (&known)
    |=> channel_output_pin_o == $past(lt)) else $error("pwm level wrong");

  cover property (tg && !mode[1] && counter_i == cmp);
  cover property (counter_tick_i && mode[6] && mode[1] && !mode[2] && (&known));
  cover property (irq_o && msk[1]);
endmodule : counter_channel_properties

bind counter_channel counter_channel_properties i_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .counter_i, .counter_tick_i, .channel_input_pin_i,
  .channel_output_pin_o, .irq_o
);

// ---- dv/test_counter_channel.sv ----
// self-checking bench of the counter-array channel 0 block
// assumes the checker is bound from its own file

module test_counter_channel
  import counter_channel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; $display("CHECK FAILED %0t mismatch", $time); end end

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'hF;
  logic [WB_DW-1:0]  wb_dat_i = 32'h0;
  logic [WB_DW-1:0]  wb_dat_o;
  logic              wb_ack_o;
  logic [CNT_W-1:0]  counter_i = 16'h0000;
  logic              counter_tick_i = 1'b0;
  logic              channel_input_pin_i = 1'b0;
  logic              channel_output_pin_o;
  logic              irq_o;
  int                bad_count = 0;
  int                checks_done = 0;
  logic [8:0]        q[$];

  counter_channel i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .counter_i, .counter_tick_i, .channel_input_pin_i,
    .channel_output_pin_o, .irq_o
  );

  initial forever #50 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // read-data monitor
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && q.size() > 0) begin
      if (q[0][8]) `CHK(wb_dat_o, {24'h000000, q[0][7:0]})
      void'(q.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic c);
    int n;
    n = 0;
    q.push_back({c, d});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      tally_and_finish();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, e, 1'b1);
  endtask : rd

  task automatic hit(input logic [15:0] v, input logic p);
    counter_i      <= v;
    counter_tick_i <= 1'b1;
    @(posedge clk_i);
    counter_tick_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(channel_output_pin_o, p)
  endtask : hit

  task automatic cap(input logic p, input logic [7:0] s);
    channel_input_pin_i <= p;
    repeat (8) @(posedge clk_i);
    `CHK(irq_o, s[1])
    rd(OFS_STATUS, s);
    wr(OFS_STATUS, 8'h03);
  endtask : cap

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] v;
    void'($urandom(31));
    v = 16'($urandom());
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(channel_output_pin_o, 1'b0)
    `CHK(irq_o, 1'b0)
    rd(OFS_MODE, 8'h00);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_MODE, 8'h01 << i);
      rd(OFS_MODE, 8'h01 << i);
    end
    wr(OFS_MODE, 8'h4D);
    wr(OFS_CMP_LOW, v[7:0]);
    rd(OFS_MODE, 8'h0D);
    wr(OFS_CMP_HIGH, v[15:8]);
    rd(OFS_MODE, 8'h4D);
    wr(OFS_MASK, 8'h03);
    rd(OFS_MASK, 8'h03);
    hit(v, 1'b1);
    `CHK(irq_o, 1'b1)
    rd(OFS_STATUS, 8'h01);
    wr(OFS_STATUS, 8'h01);
    `CHK(irq_o, 1'b0)
    wr(OFS_MODE, 8'h4C);
    hit(v, 1'b0);
    `CHK(irq_o, 1'b0)
    rd(OFS_STATUS, 8'h01);
    wr(OFS_STATUS, 8'h01);
    wr(OFS_CMP_LOW, v[7:0]);
    hit(v, 1'b0);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_MODE, 8'h46);
    hit({~v[15:8], v[7:0]}, 1'b1);
    wr(OFS_CMP_LOW, 8'h10);
    wr(OFS_CMP_HIGH, 8'h80);
    wr(OFS_MODE, 8'hC2);
    hit(16'h7FFF, 1'b1);
    hit(16'h8010, 1'b0);
    wr(OFS_MODE, 8'h42);
    hit(16'h0010, 1'b0);
    hit(16'hFF0F, 1'b1);
    wr(OFS_PWM_WIDTH, 8'h03);
    rd(OFS_PWM_WIDTH, 8'h03);
    hit(16'h0105, 1'b0);
    wr(OFS_MODE, 8'h20);
    counter_i <= 16'h1234;
    cap(1'b1, 8'h03);
    cap(1'b0, 8'h00);
    wr(OFS_MODE, 8'h10);
    cap(1'b1, 8'h00);
    cap(1'b0, 8'h03);
    rd(OFS_CMP_LOW, 8'h34);
    rd(OFS_CMP_HIGH, 8'h12);
    wr(OFS_MODE, 8'h44);
    hit(16'h1234, 1'b1);
    tally_and_finish();
  end
endmodule : test_counter_channel
